//--- hw/pmsp_top.sv
// Top: bus pins, synchronisers, register core, master and target
// Operation
// - Master moves data with memory read, write, read line, read multiple.
// - Target answers configuration and I/O reads and writes.
// - Master drives address/data only after the arbiter grants.
// - Non-multiple reads of two double words or less use memory read, else read line.
// - Master handles completion, retry, disconnect and target abort.
// - Station address PROM decodes from I/O base plus zero.
// - Indirect register data port sits at I/O base plus 10h.
// - Index port at 12h in word mode, 14h in double-word mode.
// - Reset port at 14h in word mode, 1Ch in double-word mode.
// - Bus config data port at 16h word mode, 1Ch double-word mode.
`timescale 1ns/1ns
`default_nettype none
module pmsp_top
  import pmsp_pkg::*;
#(
  parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000 // Arbitrary
)(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Bus pins
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_cbe_n,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_trdy_n,
  input  wire logic        i_stop_n,
  input  wire logic        i_devsel_n,
  input  wire logic        i_idsel,
  input  wire logic        i_gnt_n,
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic [3:0]       o_cbe_n,
  output logic             o_cbe_oe,
  output logic             o_frame_n,
  output logic             o_irdy_n,
  output logic             o_trdy_n,
  output logic             o_devsel_n,
  output logic             o_ctl_oe,
  output logic             o_tctl_oe,
  output logic             o_req_n,
  // Data engine side
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic        i_multiple,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_count,
  input  wire logic [31:0] i_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_abort,
  output logic [31:0]      o_rdata,
  output logic             o_rvalid
);
  // Two-stage synchronisers on pin inputs
  logic [31:0] ad_s1, ad_s2;
  logic [3:0]  cbe_s1, cbe_s2;
  logic [6:0]  ctl_s1, ctl_s2;
  always_ff @(posedge i_clock) begin
    ad_s1  <= i_ad;
    ad_s2  <= ad_s1;
    cbe_s1 <= i_cbe_n;
    cbe_s2 <= cbe_s1;
    ctl_s1 <= {i_frame_n, i_irdy_n, i_trdy_n, i_stop_n, i_devsel_n,
               i_idsel, i_gnt_n};
    ctl_s2 <= ctl_s1;
  end
  wire s_frame_n  = ctl_s2[6];
  wire s_irdy_n   = ctl_s2[5];
  wire s_trdy_n   = ctl_s2[4];
  wire s_stop_n   = ctl_s2[3];
  wire s_devsel_n = ctl_s2[2];
  wire s_idsel    = ctl_s2[1];
  wire s_gnt_n    = ctl_s2[0];

  logic        reg_we, bcr_we, soft_rst, master_en;
  logic [PMSP_IDX_W-1:0] reg_idx;
  logic [15:0] reg_wdata;
  logic [31:0] t_ad, m_ad;
  logic        t_ad_oe, t_trdy_n, t_devsel_n, t_oe;
  logic [3:0]  m_cbe_n;
  logic        m_frame_n, m_irdy_n, m_oe, m_req_n;
  logic        m_busy, m_done, m_abort, m_rvalid;
  logic        m_wr_q;
  logic [31:0] m_rdata;

  // Indirect register files; soft reset clears them
  logic [15:0] csr_q [PMSP_NUM_REGS];
  logic [15:0] bcr_q [PMSP_NUM_REGS];
  always_ff @(posedge i_clock) begin
    for (int k = 0; k < PMSP_NUM_REGS; k++) begin
      if (!i_rst_n || soft_rst) begin
        csr_q[k] <= 16'h0000;
        bcr_q[k] <= 16'h0000;
      end else begin
        if (reg_we && reg_idx == PMSP_IDX_W'(k)) csr_q[k] <= reg_wdata;
        if (bcr_we && reg_idx == PMSP_IDX_W'(k)) bcr_q[k] <= reg_wdata;
      end
    end
  end

  pmsp_target u_target (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_frame_n   (s_frame_n),
    .i_irdy_n    (s_irdy_n),
    .i_idsel     (s_idsel),
    .i_ad        (ad_s2),
    .i_cbe_n     (cbe_s2),
    .o_ad        (t_ad),
    .o_ad_oe     (t_ad_oe),
    .o_trdy_n    (t_trdy_n),
    .o_devsel_n  (t_devsel_n),
    .o_t_oe      (t_oe),
    .o_reg_we    (reg_we),
    .o_reg_idx   (reg_idx),
    .o_reg_wdata (reg_wdata),
    .i_reg_rdata (csr_q[reg_idx]),
    .i_bcr_rdata (bcr_q[reg_idx]),
    .o_bcr_we    (bcr_we),
    .o_soft_rst  (soft_rst),
    .o_master_en (master_en),
    .i_prom      (STATION_ADDR)
  );

  // Master jobs are held off until bus mastering is enabled in config
  pmsp_master u_master (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_start    (i_start && master_en && !t_oe),
    .i_write    (i_write),
    .i_multiple (i_multiple),
    .i_addr     (i_addr),
    .i_count    (i_count),
    .i_wdata    (i_wdata),
    .o_busy     (m_busy),
    .o_done     (m_done),
    .o_abort    (m_abort),
    .o_rdata    (m_rdata),
    .o_rvalid   (m_rvalid),
    .i_gnt_n    (s_gnt_n),
    .i_trdy_n   (s_trdy_n),
    .i_stop_n   (s_stop_n),
    .i_devsel_n (s_devsel_n),
    .i_ad       (ad_s2),
    .o_req_n    (m_req_n),
    .o_ad       (m_ad),
    .o_cbe_n    (m_cbe_n),
    .o_frame_n  (m_frame_n),
    .o_irdy_n   (m_irdy_n),
    .o_oe       (m_oe)
  );

  // Master transfer direction, latched in its address phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      m_wr_q <= 1'b0;
    end else if (m_oe && m_irdy_n) begin
      m_wr_q <= m_cbe_n[0];
    end
  end

  // Output registers; master and target never drive together
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_ad <= PMSP_RST_ZERO; o_ad_oe <= 1'b0;
      o_cbe_n <= 4'hF; o_cbe_oe <= 1'b0;
      o_frame_n <= 1'b1; o_irdy_n <= 1'b1; o_ctl_oe <= 1'b0;
      o_trdy_n <= 1'b1; o_devsel_n <= 1'b1; o_tctl_oe <= 1'b0;
      o_req_n <= 1'b1;
    end else begin
      o_ad      <= m_oe ? m_ad : t_ad;
      // A read hands the data lines to the target after the address
      o_ad_oe   <= (m_oe && (m_irdy_n || m_wr_q)) || t_ad_oe;
      o_cbe_n   <= m_cbe_n;
      o_cbe_oe  <= m_oe;
      o_frame_n <= m_frame_n;
      o_irdy_n  <= m_irdy_n;
      o_ctl_oe  <= m_oe;
      o_trdy_n  <= t_trdy_n;
      o_devsel_n <= t_devsel_n;
      o_tctl_oe <= t_oe;
      o_req_n   <= m_req_n;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0; o_done <= 1'b0; o_abort <= 1'b0;
      o_rdata <= PMSP_RST_ZERO; o_rvalid <= 1'b0;
    end else begin
      o_busy <= m_busy; o_done <= m_done; o_abort <= m_abort;
      o_rdata <= m_rdata; o_rvalid <= m_rvalid;
    end
  end

  AST_SOFT_RESET_CLEARS: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) soft_rst |=> csr_q[reg_idx] == 16'h0000 &&
    bcr_q[reg_idx] == 16'h0000)
    else $error("soft reset left register set");
  AST_NO_DUAL_DRIVE: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) !(m_oe && t_ad_oe))
    else $error("master and target both drive");
  AST_READ_TURNAROUND: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) m_oe && !m_irdy_n && !m_wr_q && !t_ad_oe
    |=> !o_ad_oe)
    else $error("master drove data lines during a read");
endmodule
`default_nettype wire

//--- hw/pmsp_pkg.sv
// Package for the bus master/target interface: commands, offsets, resets
package pmsp_pkg;
  // Bus commands (C/BE during address phase)
  localparam logic [3:0] PMSP_CMD_IO_READ    = 4'h2;
  localparam logic [3:0] PMSP_CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0] PMSP_CMD_MEM_READ   = 4'h6;
  localparam logic [3:0] PMSP_CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0] PMSP_CMD_CFG_READ   = 4'hA;
  localparam logic [3:0] PMSP_CMD_CFG_WRITE  = 4'hB;
  localparam logic [3:0] PMSP_CMD_MEM_RD_MUL = 4'hC;
  localparam logic [3:0] PMSP_CMD_MEM_RD_LN  = 4'hE;
  // I/O window offsets
  localparam logic [4:0] PMSP_OFF_PROM       = 5'h00;
  localparam logic [4:0] PMSP_OFF_RDP        = 5'h10;
  localparam logic [4:0] PMSP_OFF_IDX_WORD   = 5'h12;
  localparam logic [4:0] PMSP_OFF_IDX_DWORD  = 5'h14;
  localparam logic [4:0] PMSP_OFF_RST_WORD   = 5'h14;
  localparam logic [4:0] PMSP_OFF_BDP_WORD   = 5'h16;
  localparam logic [4:0] PMSP_OFF_RST_DWORD  = 5'h1C;
  localparam logic [4:0] PMSP_OFF_BDP_DWORD  = 5'h1C;
  localparam logic [4:0] PMSP_OFF_MODE_DWORD = 5'h10;
  // Config space offsets
  localparam logic [7:0] PMSP_CFG_ID         = 8'h00;
  localparam logic [7:0] PMSP_CFG_CMD        = 8'h04;
  localparam logic [7:0] PMSP_CFG_BAR0       = 8'h10;
  localparam logic [7:0] PMSP_CFG_INTR       = 8'h3C;
  // Reset values
  localparam logic [31:0] PMSP_RST_ZERO      = 32'h0000_0000;
  localparam logic [7:0]  PMSP_RST_INT_LINE  = 8'hFF;
  // Read line threshold in double words
  localparam int          PMSP_RD_LINE_MIN   = 3;
  // Index register file size
  localparam int          PMSP_NUM_REGS      = 32;
  localparam int          PMSP_IDX_W         = 5;
endpackage

//--- hw/pmsp_target.sv
// Bus target: config and I/O cycles, I/O window decode
`timescale 1ns/1ns
`default_nettype none
module pmsp_target
  import pmsp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Synchronised bus
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_idsel,
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_cbe_n,
  // Target outputs
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic             o_trdy_n,
  output logic             o_devsel_n,
  output logic             o_t_oe,
  // Register access to core
  output logic             o_reg_we,
  output logic [PMSP_IDX_W-1:0] o_reg_idx,
  output logic [15:0]      o_reg_wdata,
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic [15:0] i_bcr_rdata,
  output logic             o_bcr_we,
  output logic             o_soft_rst,
  output logic             o_master_en,
  input  wire logic [47:0] i_prom
);
  typedef enum logic [2:0] {
    PMSP_T_IDLE = 3'b001,
    PMSP_T_DATA = 3'b010,
    PMSP_T_DONE = 3'b100
  } pmsp_tstate_t;

  pmsp_tstate_t st_q;
  logic         wr_q;
  logic         cfg_q;
  logic [7:0]   addr_q;
  logic [31:0]  bar_q;
  logic [7:0]   int_line_q;
  logic [2:0]   cmd_q;
  logic         dword_q;
  logic [PMSP_IDX_W-1:0] idx_q;

  wire io_hit = (i_ad[31:5] == bar_q[31:5]) && cmd_q[0];
  wire is_io  = i_cbe_n == PMSP_CMD_IO_READ || i_cbe_n == PMSP_CMD_IO_WRITE;
  wire is_cfg = (i_cbe_n == PMSP_CMD_CFG_READ ||
                 i_cbe_n == PMSP_CMD_CFG_WRITE) && i_idsel;
  wire [4:0] off = addr_q[4:0];

  function automatic logic [15:0] prom_half(input logic [4:0] a);
    unique case (a[2:1])
      2'd0:    prom_half = i_prom[15:0];
      2'd1:    prom_half = i_prom[31:16];
      2'd2:    prom_half = i_prom[47:32];
      default: prom_half = 16'h0000;
    endcase
  endfunction

  // Decode depends on the I/O mode
  function automatic logic [31:0] io_read(input logic [4:0] a,
                                          input logic d);
    io_read = 32'h0000_0000;
    if (a < PMSP_OFF_RDP) begin
      io_read = {16'h0000, prom_half(a)};
    end else if (a == PMSP_OFF_RDP) begin
      io_read = {16'h0000, i_reg_rdata};
    end else if (!d && a == PMSP_OFF_IDX_WORD) begin
      io_read = {{(32-PMSP_IDX_W){1'b0}}, idx_q};
    end else if (d && a == PMSP_OFF_IDX_DWORD) begin
      io_read = {{(32-PMSP_IDX_W){1'b0}}, idx_q};
    end else if (!d && a == PMSP_OFF_BDP_WORD) begin
      io_read = {16'h0000, i_bcr_rdata};
    end else if (d && a == PMSP_OFF_BDP_DWORD) begin
      io_read = {16'h0000, i_bcr_rdata};
    end
  endfunction

  always_ff @(posedge i_clock) begin
    o_reg_we   <= 1'b0;
    o_bcr_we   <= 1'b0;
    o_soft_rst <= 1'b0;
    if (!i_rst_n) begin
      st_q <= PMSP_T_IDLE;
      wr_q <= 1'b0; cfg_q <= 1'b0; addr_q <= 8'h00;
      o_ad <= PMSP_RST_ZERO; o_ad_oe <= 1'b0;
      o_trdy_n <= 1'b1; o_devsel_n <= 1'b1; o_t_oe <= 1'b0;
    end else begin
      unique case (st_q)
        PMSP_T_IDLE: begin
          if (!i_frame_n && ((is_io && io_hit) || is_cfg)) begin
            st_q       <= PMSP_T_DATA;
            wr_q       <= i_cbe_n[0];
            cfg_q      <= is_cfg;
            addr_q     <= i_ad[7:0];
            o_devsel_n <= 1'b0;
            o_t_oe     <= 1'b1;
          end
        end
        PMSP_T_DATA: begin
          o_trdy_n <= 1'b0;
          o_ad_oe  <= !wr_q;
          if (cfg_q) begin
            unique case (addr_q & 8'hFC)
              PMSP_CFG_CMD:  o_ad <= {29'h0, cmd_q};
              PMSP_CFG_BAR0: o_ad <= {bar_q[31:5], 5'h01};
              PMSP_CFG_INTR: o_ad <= {24'h000001, int_line_q};
              default:       o_ad <= PMSP_RST_ZERO;
            endcase
          end else begin
            o_ad <= io_read(off, dword_q);
          end
          st_q <= PMSP_T_DONE;
        end
        PMSP_T_DONE: begin
          if (!i_irdy_n) begin
            st_q <= PMSP_T_IDLE;
            o_trdy_n <= 1'b1; o_devsel_n <= 1'b1;
            o_ad_oe <= 1'b0; o_t_oe <= 1'b0;
            if (!cfg_q && !wr_q && ((!dword_q && off == PMSP_OFF_RST_WORD)
                || (dword_q && off == PMSP_OFF_RST_DWORD))) begin
              o_soft_rst <= 1'b1;
            end
            if (!cfg_q && wr_q && off == PMSP_OFF_RDP) begin
              o_reg_we <= 1'b1;
            end
            if (!cfg_q && wr_q && ((!dword_q && off == PMSP_OFF_BDP_WORD)
                || (dword_q && off == PMSP_OFF_BDP_DWORD))) begin
              o_bcr_we <= 1'b1;
            end
          end
        end
        default: st_q <= PMSP_T_IDLE;
      endcase
    end
  end

  // Config and index state; the BAR is assigned by host firmware
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bar_q <= PMSP_RST_ZERO; int_line_q <= PMSP_RST_INT_LINE;
      cmd_q <= 3'b000; dword_q <= 1'b0; idx_q <= '0;
      o_reg_wdata <= 16'h0000;
    end else if (st_q == PMSP_T_DONE && !i_irdy_n && wr_q) begin
      o_reg_wdata <= i_ad[15:0];
      if (cfg_q) begin
        if ((addr_q & 8'hFC) == PMSP_CFG_CMD)  cmd_q <= i_ad[2:0];
        if ((addr_q & 8'hFC) == PMSP_CFG_BAR0) bar_q <= {i_ad[31:5], 5'h00};
        if ((addr_q & 8'hFC) == PMSP_CFG_INTR) int_line_q <= i_ad[7:0];
      end else begin
        // A 32-bit write to the data port selects double-word mode
        if (off == PMSP_OFF_MODE_DWORD && i_cbe_n == 4'h0) dword_q <= 1'b1;
        if ((!dword_q && off == PMSP_OFF_IDX_WORD) ||
            (dword_q && off == PMSP_OFF_IDX_DWORD)) begin
          idx_q <= i_ad[PMSP_IDX_W-1:0];
        end
      end
    end
  end

  assign o_reg_idx   = idx_q;
  assign o_master_en = cmd_q[2];
endmodule
`default_nettype wire

//--- hw/pmsp_master.sv
// Bus master engine: request, command choice, termination handling
`timescale 1ns/1ns
`default_nettype none
module pmsp_master
  import pmsp_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Job request
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic        i_multiple,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_count,
  input  wire logic [31:0] i_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_abort,
  output logic [31:0]      o_rdata,
  output logic             o_rvalid,
  // Synchronised bus
  input  wire logic        i_gnt_n,
  input  wire logic        i_trdy_n,
  input  wire logic        i_stop_n,
  input  wire logic        i_devsel_n,
  input  wire logic [31:0] i_ad,
  // Master outputs
  output logic             o_req_n,
  output logic [31:0]      o_ad,
  output logic [3:0]       o_cbe_n,
  output logic             o_frame_n,
  output logic             o_irdy_n,
  output logic             o_oe
);
  typedef enum logic [3:0] {
    PMSP_M_IDLE = 4'b0001,
    PMSP_M_REQ  = 4'b0010,
    PMSP_M_ADDR = 4'b0100,
    PMSP_M_DATA = 4'b1000
  } pmsp_mstate_t;

  pmsp_mstate_t st_q;
  logic [31:0]  addr_q;
  logic [7:0]   left_q;
  logic         wr_q;
  logic         mul_q;

  // Read command by length
  function automatic logic [3:0] pick_cmd(input logic w, input logic m,
                                          input logic [7:0] n);
    if (w)                         pick_cmd = PMSP_CMD_MEM_WRITE;
    else if (m)                    pick_cmd = PMSP_CMD_MEM_RD_MUL;
    else if (n >= 8'(PMSP_RD_LINE_MIN)) pick_cmd = PMSP_CMD_MEM_RD_LN;
    else                           pick_cmd = PMSP_CMD_MEM_READ;
  endfunction

  always_ff @(posedge i_clock) begin
    o_done <= 1'b0; o_abort <= 1'b0; o_rvalid <= 1'b0;
    if (!i_rst_n) begin
      st_q <= PMSP_M_IDLE; addr_q <= PMSP_RST_ZERO; left_q <= 8'h00;
      wr_q <= 1'b0; mul_q <= 1'b0; o_busy <= 1'b0; o_rdata <= PMSP_RST_ZERO;
      o_req_n <= 1'b1; o_ad <= PMSP_RST_ZERO; o_cbe_n <= 4'hF;
      o_frame_n <= 1'b1; o_irdy_n <= 1'b1; o_oe <= 1'b0;
    end else begin
      unique case (st_q)
        PMSP_M_IDLE: if (i_start && i_count != 8'h00) begin
          st_q <= PMSP_M_REQ; addr_q <= i_addr; left_q <= i_count;
          wr_q <= i_write; mul_q <= i_multiple;
          o_busy <= 1'b1; o_req_n <= 1'b0;
        end
        PMSP_M_REQ: if (!i_gnt_n) begin
          st_q <= PMSP_M_ADDR; o_oe <= 1'b1; o_frame_n <= 1'b0;
          o_ad <= addr_q; o_cbe_n <= pick_cmd(wr_q, mul_q, left_q);
        end
        PMSP_M_ADDR: begin
          st_q <= PMSP_M_DATA; o_irdy_n <= 1'b0; o_cbe_n <= 4'h0;
          o_ad <= i_wdata;
          if (left_q == 8'h01) o_frame_n <= 1'b1;
        end
        PMSP_M_DATA: begin
          // Termination kinds: complete, retry, disconnect, abort
          if (!i_trdy_n) begin
            if (!wr_q) begin
              o_rdata <= i_ad; o_rvalid <= 1'b1;
            end
            addr_q <= addr_q + 32'h4; left_q <= left_q - 8'h01;
          end
          if (!i_stop_n && i_devsel_n) begin
            st_q <= PMSP_M_IDLE; o_abort <= 1'b1; o_busy <= 1'b0;
            o_req_n <= 1'b1;
          end else if ((!i_trdy_n && left_q == 8'h01) || !i_stop_n) begin
            if (!i_trdy_n && left_q == 8'h01) begin
              st_q <= PMSP_M_IDLE; o_done <= 1'b1; o_busy <= 1'b0;
              o_req_n <= 1'b1;
            end else begin
              // Retry or disconnect: re-arbitrate for the remainder
              st_q <= PMSP_M_REQ; o_req_n <= 1'b0;
            end
          end else if (!i_trdy_n) begin
            o_ad <= i_wdata;
            if (left_q == 8'h02) o_frame_n <= 1'b1;
            st_q <= PMSP_M_DATA;
          end
          if (!i_stop_n || (!i_trdy_n && left_q == 8'h01)) begin
            o_frame_n <= 1'b1; o_irdy_n <= 1'b1; o_oe <= 1'b0;
            o_cbe_n <= 4'hF;
          end
        end
        default: st_q <= PMSP_M_IDLE;
      endcase
    end
  end

  AST_OWN_ONLY_GRANTED: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) $rose(o_oe) |-> $past(!i_gnt_n))
    else $error("master drove bus without grant");
  AST_SHORT_READ_CMD: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) (st_q == PMSP_M_REQ && !i_gnt_n && !wr_q &&
    !mul_q && left_q <= 8'h02) |=> o_cbe_n == PMSP_CMD_MEM_READ)
    else $error("short read used wrong command");
  AST_LONG_READ_CMD: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) (st_q == PMSP_M_REQ && !i_gnt_n && !wr_q &&
    !mul_q && left_q > 8'h02) |=> o_cbe_n == PMSP_CMD_MEM_RD_LN)
    else $error("long read used wrong command");
  AST_WRITE_CMD: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) (st_q == PMSP_M_REQ && !i_gnt_n && wr_q)
    |=> o_cbe_n == PMSP_CMD_MEM_WRITE)
    else $error("write used wrong command");
  AST_ABORT_ENDS: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) (st_q == PMSP_M_DATA && !i_stop_n && i_devsel_n)
    |=> o_abort && !o_busy && o_frame_n && !o_oe)
    else $error("target abort not handled");
  AST_RETRY_REARB: assert property (@(posedge i_clock)
    disable iff (!i_rst_n) (st_q == PMSP_M_DATA && !i_stop_n && !i_devsel_n
    && !(!i_trdy_n && left_q == 8'h01)) |=> st_q == PMSP_M_REQ && !o_req_n
    && o_busy)
    else $error("retry or disconnect not re-arbitrated");
endmodule
`default_nettype wire

//--- testbench/pmsp_bus_partner.sv
// Arbiter and memory target model facing the master engine
`timescale 1ns/1ns
`default_nettype none
module pmsp_bus_partner (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Master side of the bus
  input  wire logic        i_req_n,
  input  wire logic        i_ctl_oe,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic [3:0]  i_cbe_n,
  input  wire logic [31:0] i_ad,
  input  wire logic [2:0]  i_mode,
  // Responses
  output logic             o_gnt_n,
  output logic             o_devsel_n,
  output logic             o_trdy_n,
  output logic             o_stop_n,
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic [3:0]       o_cmd
);
  logic       act_q;
  logic       tried_q;
  logic [3:0] wait_q;
  logic       live;
  logic       norm;
  assign live = i_ctl_oe && !(i_frame_n && i_irdy_n);
  // Retry answers only the first attempt, then completes normally
  assign norm = i_mode[1:0] == 2'h0 || (i_mode[1:0] == 2'h1 && tried_q);
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      {o_gnt_n, o_devsel_n, o_trdy_n, o_stop_n} <= 4'hF;
      {act_q, tried_q, o_ad_oe} <= 3'h0;
      wait_q <= 4'h0;
      o_cmd <= 4'h0;
      o_ad <= 32'h0;
    end else begin
      wait_q <= i_req_n ? 4'h0 : wait_q + {3'h0, wait_q != 4'hF};
      // Slow mode holds the grant back eight cycles
      o_gnt_n <= i_req_n || (i_mode[2] && wait_q < 4'h8);
      if (live && !act_q) begin
        act_q <= 1'b1;
        o_cmd <= i_cbe_n;
        o_ad <= i_ad;
      end else if (live) begin
        o_devsel_n <= i_mode[1:0] == 2'h2;
        o_trdy_n <= !(norm || i_mode[1:0] == 2'h3);
        o_stop_n <= norm;
        o_ad_oe <= !o_cmd[0];
      end else begin
        {o_devsel_n, o_trdy_n, o_stop_n} <= 3'h7;
        o_ad_oe <= 1'b0;
        o_ad <= ~o_ad;
        tried_q <= tried_q || (act_q && i_mode[1:0] == 2'h1);
        act_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/pmsp_top_tb_top.sv
// Self-checking bench: host cycles, master jobs, partner model
`timescale 1ns/1ns
`default_nettype none
module pmsp_top_tb_top;
  import pmsp_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        h_oe = 1'b0;
  logic        frame_n = 1'b1;
  logic        irdy_n = 1'b1;
  logic        idsel = 1'b0;
  logic [3:0]  cbe_n = 4'hF;
  logic [31:0] h_ad = 32'h0;
  logic        start = 1'b0;
  logic        wr = 1'b0;
  logic        mul = 1'b0;
  logic [7:0]  cnt = 8'h1;
  logic [2:0]  mode = 3'h0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] rd;
  logic [31:0] d_ad, p_ad, bad, rdata;
  logic [3:0]  d_cbe, bcbe, p_cmd;
  logic        d_ad_oe, cbe_oe, d_frame, d_irdy, d_trdy, d_dev, ctl_oe;
  logic        tctl_oe, req_n, gnt_n, p_dev, p_trdy, p_stop, p_oe;
  logic        bframe, birdy, busy, done, abort, rvalid;
  int          fail_count = 0;
  int          n_checks = 0;
  int          nrv = 0;
  // Undriven data lines show a changing pattern, never a stale value
  assign bad = d_ad_oe ? d_ad : h_oe ? h_ad : p_oe ? p_ad : cyc;
  assign bframe = ctl_oe ? d_frame : frame_n;
  assign birdy = ctl_oe ? d_irdy : irdy_n;
  assign bcbe = cbe_oe ? d_cbe : cbe_n;
  pmsp_top #(.STATION_ADDR(48'h0000_0000_C3A5)) i_pmsp_top (
    .i_clock(clk), .i_rst_n(rst_n), .i_ad(bad), .i_cbe_n(bcbe),
    .i_frame_n(bframe), .i_irdy_n(birdy), .i_trdy_n(p_trdy),
    .i_stop_n(p_stop), .i_devsel_n(p_dev), .i_idsel(idsel),
    .i_gnt_n(gnt_n), .o_ad(d_ad), .o_ad_oe(d_ad_oe), .o_cbe_n(d_cbe),
    .o_cbe_oe(cbe_oe), .o_frame_n(d_frame), .o_irdy_n(d_irdy),
    .o_trdy_n(d_trdy), .o_devsel_n(d_dev), .o_ctl_oe(ctl_oe),
    .o_tctl_oe(tctl_oe), .o_req_n(req_n), .i_start(start), .i_write(wr),
    .i_multiple(mul), .i_addr(32'h0000_2000), .i_count(cnt),
    .i_wdata(32'h1234_5678), .o_busy(busy), .o_done(done),
    .o_abort(abort), .o_rdata(rdata), .o_rvalid(rvalid));
  pmsp_bus_partner i_pmsp_bus_partner (
    .i_clock(clk), .i_rst_n(rst_n), .i_req_n(req_n), .i_ctl_oe(ctl_oe),
    .i_frame_n(bframe), .i_irdy_n(birdy), .i_cbe_n(bcbe), .i_ad(bad),
    .i_mode(mode), .o_gnt_n(gnt_n), .o_devsel_n(p_dev), .o_trdy_n(p_trdy),
    .o_stop_n(p_stop), .o_ad(p_ad), .o_ad_oe(p_oe), .o_cmd(p_cmd));
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 32'h1;
  always @(posedge clk) if (rvalid === 1'b1) nrv <= nrv + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Host holds ready until the target's ready is seen, as the bus asks
  task automatic cyc_io(input logic [3:0] c, input logic [31:0] a,
                        input logic [3:0] be, input logic [31:0] w,
                        input logic ack);
    int k;
    h_oe = 1'b1;
    frame_n = 1'b0;
    idsel = c[3];
    h_ad = a;
    cbe_n = c;
    tick(1);
    frame_n = 1'b1;
    irdy_n = 1'b0;
    cbe_n = be;
    h_oe = c[0];
    h_ad = w;
    idsel = 1'b0;
    for (k = 0; k < 30 && d_trdy !== 1'b0; k++) tick(1);
    chk("claimed", {31'h0, ack}, {31'h0, k != 30});
    if (ack && k == 30) complete_run;
    if (ack) chk("devsel", 32'h0, {31'h0, d_dev});
    rd = d_ad;
    tick(1);
    irdy_n = 1'b1;
    h_oe = 1'b0;
    cbe_n = 4'hF;
    tick(10);
  endtask
  task automatic io_wr(input logic [4:0] o, input logic [3:0] be,
                       input logic [31:0] d);
    cyc_io(PMSP_CMD_IO_WRITE, BASE | {27'h0, o}, be, d, 1'b1);
  endtask
  task automatic rchk(input string s, input logic [4:0] o,
                      input logic [15:0] e);
    cyc_io(PMSP_CMD_IO_READ, BASE | {27'h0, o}, 4'hC, 32'h0, 1'b1);
    chk(s, {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic job(input logic w, input logic m, input logic [7:0] n,
                     input logic [2:0] md, input logic [3:0] ec,
                     input logic ab);
    int k;
    int n0;
    mode = md;
    wr = w;
    mul = m;
    cnt = n;
    n0 = nrv;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 900 && done !== 1'b1 && abort !== 1'b1; k++) tick(1);
    chk("finished", 32'h1, {31'h0, k != 900});
    if (k == 900) complete_run;
    chk("abort", {31'h0, ab}, {31'h0, abort});
    chk("command", {28'h0, ec}, {28'h0, p_cmd});
    chk("busy", 32'h0, {31'h0, busy});
    // The last data pulse leaves the outputs together with done
    tick(1);
    if (!w && !ab) chk("beats", {24'h0, n}, nrv - n0);
    tick(9);
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(3);
    cyc_io(PMSP_CMD_CFG_WRITE, 32'h10, 4'h0, BASE, 1'b1);
    cyc_io(PMSP_CMD_CFG_WRITE, 32'h04, 4'h0, 32'h5, 1'b1);
    cyc_io(PMSP_CMD_CFG_READ, 32'h10, 4'h0, 32'h0, 1'b1);
    chk("base", BASE, rd & 32'hFFFF_FFE0);
    rchk("prom", PMSP_OFF_PROM, 16'hC3A5);
    io_wr(PMSP_OFF_IDX_WORD, 4'hC, 32'h0003_0003);
    io_wr(PMSP_OFF_RDP, 4'hC, 32'hA55A_A55A);
    rchk("data_word", PMSP_OFF_RDP, 16'hA55A);
    io_wr(PMSP_OFF_BDP_WORD, 4'hC, 32'h1234_1234);
    rchk("bcfg_word", PMSP_OFF_BDP_WORD, 16'h1234);
    rchk("idx_word", PMSP_OFF_IDX_WORD, 16'h0003);
    cyc_io(PMSP_CMD_IO_READ, BASE | 32'h14, 4'hC, 32'h0, 1'b1);
    io_wr(PMSP_OFF_IDX_WORD, 4'hC, 32'h0003_0003);
    rchk("cleared_word", PMSP_OFF_RDP, 16'h0);
    io_wr(PMSP_OFF_MODE_DWORD, 4'h0, 32'h0);
    io_wr(PMSP_OFF_IDX_DWORD, 4'h0, 32'h5);
    io_wr(PMSP_OFF_RDP, 4'h0, 32'h0000_BEEF);
    rchk("data_dword", PMSP_OFF_RDP, 16'hBEEF);
    io_wr(PMSP_OFF_BDP_DWORD, 4'h0, 32'h0000_5A5A);
    rchk("bcfg_dword", PMSP_OFF_BDP_DWORD, 16'h5A5A);
    io_wr(PMSP_OFF_IDX_DWORD, 4'h0, 32'h5);
    rchk("cleared_dword", PMSP_OFF_RDP, 16'h0);
    cyc_io(PMSP_CMD_IO_READ, 32'h3000, 4'hC, 32'h0, 1'b0);
    job(1'b0, 1'b0, 8'd2, 3'h0, PMSP_CMD_MEM_READ, 1'b0);
    chk("rdata", 32'h0000_2000, rdata);
    job(1'b0, 1'b0, 8'd3, 3'h4, PMSP_CMD_MEM_RD_LN, 1'b0);
    job(1'b0, 1'b1, 8'd3, 3'h0, PMSP_CMD_MEM_RD_MUL, 1'b0);
    job(1'b1, 1'b0, 8'd2, 3'h0, PMSP_CMD_MEM_WRITE, 1'b0);
    job(1'b0, 1'b0, 8'd1, 3'h1, PMSP_CMD_MEM_READ, 1'b0);
    job(1'b0, 1'b0, 8'd3, 3'h3, PMSP_CMD_MEM_READ, 1'b0);
    job(1'b0, 1'b0, 8'd1, 3'h2, PMSP_CMD_MEM_READ, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
